// ==== design/csm_pkg.sv ====
// Package for the completion space manager: offsets, fields, limits, state.
// Assumes a 32-bit AHB-Lite bus and one clock at 100 MHz.
package csm_pkg;
  // Register byte offsets
  localparam logic [7:0] CSM_CTRL_OFS = 8'h00;
  localparam logic [7:0] CSM_PEND_OFS = 8'h04;
  localparam logic [7:0] CSM_ERR_OFS = 8'h08;
  localparam logic [7:0] CSM_LIMIT_OFS = 8'h0C;
  // Control fields
  localparam int CSM_CTRL_ENABLE_BIT = 0;
  localparam int CSM_CTRL_HIGH_BIT = 1;
  localparam int CSM_CTRL_USECFG_BIT = 2;
  localparam logic CSM_ENABLE_RST = 1'b0;
  localparam logic CSM_HIGH_RST = 1'b0;
  localparam logic CSM_USECFG_RST = 1'b0;
  // Error fields, write one to clear
  localparam int CSM_ERR_SIZE_BIT = 0;
  localparam int CSM_ERR_FRAG_BIT = 1;
  // Pending and limit field positions
  localparam int CSM_HDR_LSB = 0;
  localparam int CSM_DATA_LSB = 16;
  // Completion space
  localparam logic [6:0] CSM_HDR_TOTAL = 7'h40;
  localparam int CSM_DATA_GOOD_BYTES = 7936;
  localparam int CSM_DATA_HIGH_BYTES = 15872;
  localparam int CSM_CREDIT_BYTES = 16;
  localparam logic [9:0] CSM_DATA_GOOD_CRED = 10'(CSM_DATA_GOOD_BYTES / CSM_CREDIT_BYTES);
  localparam logic [9:0] CSM_DATA_HIGH_CRED = 10'(CSM_DATA_HIGH_BYTES / CSM_CREDIT_BYTES);
  // Request size and completion boundary
  localparam logic [12:0] CSM_MRS_MIN_BYTES = 13'h0080;
  localparam logic [2:0] CSM_MRS_MAX_CODE = 3'h5;
  localparam logic [3:0] CSM_RCB64_CRED = 4'h4;
  localparam logic [3:0] CSM_RCB128_CRED = 4'h8;
  localparam int CSM_TAG_W = 5;
  localparam int CSM_ENTRY_W = 24;

  typedef struct packed {
    logic enable;
    logic perf_high;
    logic use_cfg;
    logic [6:0] pend_h;
    logic [9:0] pend_d;
    logic err_size;
    logic err_frag;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic grant;
    logic reject;
    logic rel_v;
    logic rel_last;
    logic [6:0] rel_end;
    logic hreadyout;
  } csm_state_t;

  localparam csm_state_t CSM_STATE_RST = '{enable: CSM_ENABLE_RST, perf_high: CSM_HIGH_RST,
    use_cfg: CSM_USECFG_RST, pend_h: 7'h00, pend_d: 10'h000, err_size: 1'b0, err_frag: 1'b0,
    wr_pend: 1'b0, wr_addr: 8'h00, rdata: 32'h0000_0000, grant: 1'b0, reject: 1'b0,
    rel_v: 1'b0, rel_last: 1'b0, rel_end: 7'h00, hreadyout: 1'b1};
endpackage

// ==== design/csm_tag_mem.sv ====
// Per-tag store of reserved credits, boundary and expected end.
// Assumes one write and one read port on the same clock.
`timescale 1ns/100ps
module csm_tag_mem import csm_pkg::*; (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [CSM_TAG_W-1:0] wr_addr,
  input wire logic [CSM_ENTRY_W-1:0] wr_data,
  input wire logic [CSM_TAG_W-1:0] rd_addr,
  output logic [CSM_ENTRY_W-1:0] rd_data
);
  logic [CSM_ENTRY_W-1:0] mem [0:(1<<CSM_TAG_W)-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // csm_tag_mem

// ==== design/csm_space_mgr.sv ====
// Completion space manager: gates outbound reads on free completion credits.
// Assumes an AHB-Lite master, the core's config outputs and a completion parser.
`timescale 1ns/100ps
module csm_space_mgr import csm_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] cfg_dev_ctrl,
  input wire logic [1:0] cfg_rcb_status,
  input wire logic req_valid,
  input wire logic [11:0] req_addr,
  input wire logic [12:0] req_len,
  input wire logic [CSM_TAG_W-1:0] req_tag,
  input wire logic req_func,
  output logic req_grant,
  output logic req_reject,
  input wire logic cpl_valid,
  input wire logic [CSM_TAG_W-1:0] cpl_tag,
  input wire logic [6:0] cpl_lower_addr,
  input wire logic [12:0] cpl_len,
  input wire logic cpl_last
);
  csm_state_t st, nx;
  logic [CSM_ENTRY_W-1:0] ent;
  logic [2:0] mrs_code;
  logic [12:0] mrs_bytes;
  logic rcb128;
  logic [3:0] rcb_cred;
  logic [13:0] sum64, sum128, sumd;
  logic [6:0] need_h;
  logic [8:0] need_d;
  logic [9:0] data_total;
  logic take, oversize, fits, take_ok, rel_now;
  logic [6:0] req_end;
  logic [6:0] ent_h, ent_end;
  logic [8:0] ent_d;
  logic ent_rcb;

  assign mrs_code = cfg_dev_ctrl[14:12];
  assign mrs_bytes = (st.use_cfg && mrs_code <= CSM_MRS_MAX_CODE) ?
    13'(CSM_MRS_MIN_BYTES << mrs_code) : CSM_MRS_MIN_BYTES;
  assign rcb128 = st.use_cfg & cfg_rcb_status[req_func];
  assign rcb_cred = rcb128 ? CSM_RCB128_CRED : CSM_RCB64_CRED;
  assign sum64 = 14'(req_addr[5:0]) + 14'(req_len) + 14'h003F;
  assign sum128 = 14'(req_addr[6:0]) + 14'(req_len) + 14'h007F;
  assign need_h = rcb128 ? 7'(sum128 >> 7) : 7'(sum64 >> 6);
  assign sumd = 14'(req_addr[3:0]) + 14'(req_len) + 14'h000F;
  assign need_d = 9'(sumd >> 4);
  assign data_total = st.perf_high ? CSM_DATA_HIGH_CRED : CSM_DATA_GOOD_CRED;
  assign take = req_valid & st.enable & ~st.grant & ~st.reject;
  assign oversize = (req_len > mrs_bytes) || (req_len == 13'h0000);
  assign fits = (8'(st.pend_h) + 8'(need_h) <= 8'(CSM_HDR_TOTAL))
    && (11'(st.pend_d) + 11'(need_d) <= 11'(data_total));
  assign take_ok = take & ~oversize & fits;
  assign req_end = 7'(req_addr[6:0] + req_len[6:0]);
  assign {ent_rcb, ent_h, ent_d, ent_end} = ent;
  assign rel_now = st.rel_v & st.rel_last;

  csm_tag_mem u_mem (
    .clk(clk),
    .wr_en(take_ok),
    .wr_addr(req_tag),
    .wr_data({rcb128, need_h, need_d, req_end}),
    .rd_addr(cpl_tag),
    .rd_data(ent)
  );

  always_comb begin
    nx = st;
    nx.grant = 1'b0;
    nx.reject = 1'b0;
    // Data phase of a write
    if (st.wr_pend) begin
      if (st.wr_addr == CSM_CTRL_OFS) begin
        nx.enable = hwdata[CSM_CTRL_ENABLE_BIT];
        nx.perf_high = hwdata[CSM_CTRL_HIGH_BIT];
        nx.use_cfg = hwdata[CSM_CTRL_USECFG_BIT];
      end else if (st.wr_addr == CSM_ERR_OFS) begin
        nx.err_size = st.err_size & ~hwdata[CSM_ERR_SIZE_BIT];
        nx.err_frag = st.err_frag & ~hwdata[CSM_ERR_FRAG_BIT];
      end
    end
    // Address phase
    nx.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      nx.wr_pend = hwrite;
      nx.wr_addr = haddr[7:0];
      nx.rdata = 32'h0000_0000;
      if (!hwrite) begin
        case (haddr[7:0])
          CSM_CTRL_OFS: begin
            nx.rdata[CSM_CTRL_ENABLE_BIT] = st.enable;
            nx.rdata[CSM_CTRL_HIGH_BIT] = st.perf_high;
            nx.rdata[CSM_CTRL_USECFG_BIT] = st.use_cfg;
          end
          CSM_PEND_OFS: begin
            nx.rdata[CSM_HDR_LSB +: 7] = st.pend_h;
            nx.rdata[CSM_DATA_LSB +: 10] = st.pend_d;
          end
          CSM_ERR_OFS: begin
            nx.rdata[CSM_ERR_SIZE_BIT] = st.err_size;
            nx.rdata[CSM_ERR_FRAG_BIT] = st.err_frag;
          end
          CSM_LIMIT_OFS: begin
            nx.rdata[CSM_HDR_LSB +: 7] = CSM_HDR_TOTAL;
            nx.rdata[CSM_DATA_LSB +: 10] = data_total;
          end
          default: nx.rdata = 32'h0000_0000;
        endcase
      end
    end
    // Request admission
    if (take && oversize) begin
      nx.reject = 1'b1;
      nx.err_size = 1'b1;
    end else if (take_ok) begin
      nx.grant = 1'b1;
    end
    // Reserve and release in one update
    nx.pend_h = 7'(st.pend_h + (take_ok ? need_h : 7'h00) - (rel_now ? ent_h : 7'h00));
    nx.pend_d = 10'(st.pend_d + (take_ok ? 10'(need_d) : 10'h000) - (rel_now ? 10'(ent_d) : 10'h000));
    // Completion fragmentation check
    if (st.rel_v) begin
      if (st.rel_last) begin
        if (st.rel_end != ent_end) begin
          nx.err_frag = 1'b1;
        end
      end else if (ent_rcb ? (st.rel_end != 7'h00) : (st.rel_end[5:0] != 6'h00)) begin
        nx.err_frag = 1'b1;
      end
    end
    nx.rel_v = cpl_valid;
    nx.rel_last = cpl_last;
    nx.rel_end = 7'(cpl_lower_addr + cpl_len[6:0]);
    nx.hreadyout = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= CSM_STATE_RST;
    end else begin
      st <= nx;
    end
  end

  assign hrdata = st.rdata;
  assign hreadyout = st.hreadyout;
  assign hresp = 1'b0;
  assign req_grant = st.grant;
  assign req_reject = st.reject;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_hdr_bound: assert property (st.pend_h <= CSM_HDR_TOTAL) else $error("header credits over limit");
  a_data_bound: assert property (st.pend_d <= data_total) else $error("data credits over limit");
  a_grant_pulse: assert property (req_grant |=> !req_grant) else $error("grant held twice");
  a_reserve_hdr: assert property (
    take_ok && !rel_now |=> (7'(st.pend_h - $past(st.pend_h)) == $past(need_h)))
    else $error("header reservation wrong");
  a_reserve_data: assert property (
    take_ok && !rel_now |=> (10'(st.pend_d - $past(st.pend_d)) == 10'($past(need_d))))
    else $error("data reservation wrong");
  a_release_hdr: assert property (
    rel_now && !take_ok |=> (7'($past(st.pend_h) - st.pend_h) == $past(ent_h)))
    else $error("header release wrong");
  a_wait_full: assert property (
    take && !oversize && !fits |=> !req_grant && !req_reject)
    else $error("request granted without space");
  a_disabled_quiet: assert property (
    !st.enable |=> !req_grant && !req_reject)
    else $error("request answered while disabled");
  a_oversize_refuse: assert property (
    take && oversize |=> req_reject && !req_grant && st.err_size)
    else $error("oversize read not refused");
  a_mrs_decode: assert property (
    st.use_cfg && mrs_code == 3'h5 |-> mrs_bytes == 13'h1000)
    else $error("size code decode wrong");
  a_mrs_default: assert property (
    !st.use_cfg || mrs_code > CSM_MRS_MAX_CODE |-> mrs_bytes == CSM_MRS_MIN_BYTES)
    else $error("default request size wrong");
  a_rcb_func: assert property (
    st.use_cfg && cfg_rcb_status[req_func] |-> rcb_cred == CSM_RCB128_CRED)
    else $error("boundary credits wrong");
  a_rcb_default: assert property (
    !st.use_cfg |-> rcb_cred == CSM_RCB64_CRED)
    else $error("default boundary wrong");
  a_mid_frag: assert property (
    st.rel_v && !st.rel_last && st.rel_end[5:0] != 6'h00 |=> st.err_frag)
    else $error("bad middle fragment missed");
  a_last_end: assert property (
    st.rel_v && st.rel_last && st.rel_end != ent_end |=> st.err_frag)
    else $error("bad final end missed");

  c_grant: cover property (take_ok ##1 req_grant);
  c_reject: cover property (take && oversize ##1 req_reject);
  c_wait_then_grant: cover property (req_valid && !fits ##1 req_valid [*2] ##1 req_grant);
  c_release_and_take: cover property (rel_now && take_ok);
  c_frag_err: cover property (st.rel_v && !st.err_frag ##1 st.err_frag);
endmodule // csm_space_mgr

// ==== tb/csm_cpl_partner.sv ====
// Link partner model: returns the completions of one granted read.
// Assumes the bench calls send only after the read was granted.
`timescale 1ns/100ps
module csm_cpl_partner import csm_pkg::*; (
  input wire logic clk,
  output logic cpl_valid,
  output logic [CSM_TAG_W-1:0] cpl_tag,
  output logic [6:0] cpl_lower_addr,
  output logic [12:0] cpl_len,
  output logic cpl_last
);
  initial begin
    {cpl_valid, cpl_tag, cpl_lower_addr, cpl_len, cpl_last} = '0;
  end
  // Bad cuts the first completion short of its boundary
  task automatic send(input logic [CSM_TAG_W-1:0] tag, input logic [12:0] a, input logic [12:0] n,
    input logic [12:0] rcb, input logic bad);
    logic [12:0] e;
    logic [12:0] c;
    e = a + n;
    while (a < e) begin
      c = (a / rcb + 13'h1) * rcb;  // Cut at next boundary
      if (c > e) c = e;  // Final one ends at request end
      if (bad && c < e) c = c - 13'h4;
      bad = 1'b0;
      @(posedge clk);
      {cpl_valid, cpl_tag, cpl_lower_addr, cpl_len, cpl_last} <= {1'b1, tag, a[6:0], c - a, c == e};
      @(posedge clk);
      {cpl_valid, cpl_tag, cpl_lower_addr, cpl_len, cpl_last} <= {1'b0, ~tag, ~a[6:0], ~(c - a), c != e};
      a = c;
    end
  endtask
endmodule  // csm_cpl_partner

// ==== tb/completion_space_manager_tb_top.sv ====
// Testbench for the completion space manager.
// Assumes the design, its package and the completion partner model.
`timescale 1ns/100ps
module completion_space_manager_tb_top import csm_pkg::*;;
  logic clk, rstn, hsel, hwrite, hreadyout, hresp, req_valid, req_func, req_grant, req_reject, cpl_valid, cpl_last;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, cfg_rcb_status;
  logic [15:0] cfg_dev_ctrl;
  logic [11:0] req_addr;
  logic [12:0] req_len, cpl_len;
  logic [CSM_TAG_W-1:0] req_tag, cpl_tag;
  logic [6:0] cpl_lower_addr;
  int failures, n_tests, waited;
  csm_space_mgr dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cfg_dev_ctrl(cfg_dev_ctrl), .cfg_rcb_status(cfg_rcb_status), .req_valid(req_valid), .req_addr(req_addr),
    .req_len(req_len), .req_tag(req_tag), .req_func(req_func), .req_grant(req_grant), .req_reject(req_reject),
    .cpl_valid(cpl_valid), .cpl_tag(cpl_tag), .cpl_lower_addr(cpl_lower_addr), .cpl_len(cpl_len),
    .cpl_last(cpl_last));
  csm_cpl_partner lp (.clk(clk), .cpl_valid(cpl_valid), .cpl_tag(cpl_tag), .cpl_lower_addr(cpl_lower_addr),
    .cpl_len(cpl_len), .cpl_last(cpl_last));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic give_up();
    failures++;
    print_verdict();
  endtask
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One single word transfer, address phase then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, 24'h0, a, w};
    for (int p = 0; p < 2; p++) begin
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (hreadyout !== 1'b1) give_up();
      if (p == 0) {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    end
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(nm, exp, rd);
  endtask
  // Holds the request until grant or refusal is seen
  task automatic req(input logic [11:0] a, input logic [12:0] n, input logic [CSM_TAG_W-1:0] t, input logic f,
    input logic [1:0] exp);
    @(posedge clk);
    {req_valid, req_addr, req_len, req_tag, req_func} <= {1'b1, a, n, t, f};
    waited = 0;
    do begin
      @(posedge clk);
      waited++;
    end while (req_grant !== 1'b1 && req_reject !== 1'b1 && waited < 200);
    cmp("grant reject", {30'h0, exp}, {30'h0, req_grant, req_reject});
    if (req_grant !== 1'b1 && req_reject !== 1'b1) give_up();
    {req_valid, req_addr, req_len, req_tag, req_func} <= {1'b0, ~a, ~n, ~t, ~f};
  endtask
  initial begin
    logic [12:0] sz;
    {rstn, hsel, htrans, haddr, hwrite, hwdata} = '0;
    {req_valid, req_addr, req_len, req_tag, req_func} = '0;
    cfg_dev_ctrl = 16'h5000;
    cfg_rcb_status = 2'h2;
    failures = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    chk("ctrl", CSM_CTRL_OFS, 32'h0);
    chk("limit good", CSM_LIMIT_OFS, 32'h01F0_0040);
    wr(CSM_PEND_OFS, 32'hFFFF_FFFF);
    chk("pend ro", CSM_PEND_OFS, 32'h0);
    chk("unmapped", 8'h10, 32'h0);
    cmp("hresp", 32'h0, {31'h0, hresp});
    $display("test reset done");
    wr(CSM_CTRL_OFS, 32'h1);
    req(12'h0, 13'h080, 5'h1, 1'b1, 2'h2);
    req(12'h0, 13'h081, 5'h2, 1'b0, 2'h1);
    chk("pend dflt", CSM_PEND_OFS, 32'h0008_0002);
    chk("err size", CSM_ERR_OFS, 32'h1);
    wr(CSM_ERR_OFS, 32'h1);
    chk("err clr", CSM_ERR_OFS, 32'h0);
    lp.send(5'h1, 13'h0, 13'h080, 13'h040, 1'b0);
    chk("pend rel", CSM_PEND_OFS, 32'h0);
    $display("test defaults done");
    wr(CSM_CTRL_OFS, 32'h5);
    for (int c = 0; c < 8; c++) begin
      sz = (c < 6) ? 13'h080 << c : 13'h080;
      cfg_dev_ctrl <= {1'b0, 3'(c), 12'h0};
      req(12'h0, sz + 13'h1, 5'h3, 1'b0, 2'h1);
      req(12'h0, sz, 5'h3, 1'b0, 2'h2);
      chk("pend size", CSM_PEND_OFS, {6'h0, 10'(sz >> 4), 9'h0, 7'(sz >> 6)});
      lp.send(5'h3, 13'h0, sz, 13'h040, 1'b0);
    end
    $display("test sizes done");
    wr(CSM_ERR_OFS, 32'h3);
    req(12'h03C, 13'h008, 5'h4, 1'b0, 2'h2);
    req(12'h03C, 13'h008, 5'h5, 1'b1, 2'h2);
    chk("pend rcb", CSM_PEND_OFS, 32'h0004_0003);
    lp.send(5'h4, 13'h03C, 13'h008, 13'h040, 1'b0);
    lp.send(5'h5, 13'h03C, 13'h008, 13'h080, 1'b0);
    chk("pend rel2", CSM_PEND_OFS, 32'h0);
    $display("test boundary done");
    wr(CSM_CTRL_OFS, 32'h7);
    chk("limit high", CSM_LIMIT_OFS, 32'h03E0_0040);
    cfg_dev_ctrl <= 16'h5000;
    req(12'h0, 13'h1000, 5'h6, 1'b1, 2'h2);
    req(12'h0, 13'h1000, 5'h7, 1'b1, 2'h2);
    fork
      req(12'h0, 13'h1000, 5'h8, 1'b1, 2'h2);
      begin
        repeat (30) @(posedge clk);
        lp.send(5'h6, 13'h0, 13'h1000, 13'h080, 1'b0);
      end
    join
    cmp("held", 32'h1, {31'h0, waited > 30});
    chk("pend full", CSM_PEND_OFS, 32'h0200_0040);
    lp.send(5'h7, 13'h0, 13'h1000, 13'h080, 1'b0);
    lp.send(5'h8, 13'h0, 13'h1000, 13'h080, 1'b0);
    $display("test hold done");
    req(12'h0, 13'h100, 5'h9, 1'b0, 2'h2);
    lp.send(5'h9, 13'h0, 13'h100, 13'h040, 1'b1);
    chk("err frag", CSM_ERR_OFS, 32'h2);
    chk("pend end", CSM_PEND_OFS, 32'h0);
    wr(CSM_ERR_OFS, 32'h2);
    req(12'h0, 13'h100, 5'hA, 1'b0, 2'h2);
    lp.send(5'hA, 13'h0, 13'h0FC, 13'h040, 1'b0);
    chk("err end", CSM_ERR_OFS, 32'h2);
    chk("pend end2", CSM_PEND_OFS, 32'h0);
    $display("test fragment done");
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    chk("ctrl rst", CSM_CTRL_OFS, 32'h0);
    chk("err rst", CSM_ERR_OFS, 32'h0);
    chk("limit rst", CSM_LIMIT_OFS, 32'h01F0_0040);
    $display("test reset again done");
    print_verdict();
  end
endmodule  // completion_space_manager_tb_top
